// [pkg/asc_pkg.sv]
// constants and types shared by the serial converter control port
package asc_pkg;
  localparam int REF_CLK_NS        = 4;    // reference clock period, ns
  localparam int SYS_CLK_NS_DEF    = 256;  // internal system clock period, ns
  localparam int CONV_SYS_CLKS_DEF = 22;   // system clocks for one conversion
  localparam int RES_BITS          = 10;   // result width
  localparam int CHAN_COUNT        = 11;   // analog input channels
  localparam int ADDR_BITS         = 4;    // serial channel address width
  localparam int CNT_W             = 4;    // width of the edge counters
  localparam int ADDR_EDGES        = 4;    // rising edges that carry the address
  localparam int SAMPLE_EDGE       = 4;    // falling edge that opens sampling
  localparam int LSB_EDGE          = 9;    // falling edge that shows the lsb
  localparam int LAST_EDGE         = 10;   // falling edge that starts conversion
  localparam int CS_SYS_EDGES      = 2;    // system clock edges to qualify select
  localparam int LINK_PINS         = 3;    // select, shift clock, address

  // conversion controller states
  typedef enum logic {
    ASC_IDLE,
    ASC_CONVERT
  } asc_conv_t;
endpackage : asc_pkg

// [rtl/asc_sync.sv]
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module asc_sync #(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  // both stages of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] ff1;  // first stage, read only by the second
    logic [WIDTH-1:0] ff2;  // second stage, safe to use
  } asc_sync_t;

  localparam asc_sync_t RST_STATE = '{ff1: RST_VAL, ff2: RST_VAL};

  asc_sync_t s_q;
  asc_sync_t s_d;

  // next state: shift the pins through the two stages
  always_comb begin
    s_d     = s_q;
    s_d.ff1 = i_d;
    s_d.ff2 = s_q.ff1;
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.ff2;
endmodule : asc_sync

// [rtl/asc_port.sv]
// serial control and readout port of a 10-bit converter with input multiplexer
//
// Behaviour
// - latched address routes one of eleven channels
// - select fall resets counters, enables after two ticks
// - select rise disables inputs after two ticks
// - result output undriven while select is high
// - previous result msb appears on enable
// - each shift clock fall advances one bit
// - tenth fall and later drive output low
// - end flag low from tenth fall until done
// - address captured msb first on four rises
// - sampling runs from fourth to tenth fall
// - tenth fall hands over to internal controller
`timescale 1ns/1ns
module asc_port #(
  parameter int SYS_CLK_NS    = asc_pkg::SYS_CLK_NS_DEF,     // internal clock period, ns
  parameter int CONV_SYS_CLKS = asc_pkg::CONV_SYS_CLKS_DEF   // conversion length, ticks
) (
  input  wire logic        i_ref_clk,       // 250 MHz reference clock
  input  wire logic        i_rst,           // asynchronous reset, active high
  input  wire logic        i_cs_n,          // chip select pin, active low
  input  wire logic        i_io_clk,        // host shift clock pin
  input  wire logic        i_address,       // serial channel address pin
  input  wire logic [asc_pkg::CHAN_COUNT*asc_pkg::RES_BITS-1:0] i_analog_inputs,
  output logic             o_data_out,      // serial result, level
  output logic             o_data_out_oe,   // result pin driven while high
  output logic             o_eoc,           // end of conversion, high when ready
  output logic             o_sampling,      // selected channel being sampled
  output logic [asc_pkg::ADDR_BITS-1:0] o_chan_sel  // multiplexer selection
);
  localparam int RB     = asc_pkg::RES_BITS;
  localparam int CW     = asc_pkg::CNT_W;
  localparam int DIV    = SYS_CLK_NS / asc_pkg::REF_CLK_NS;  // ref clocks per tick
  localparam int DIV_W  = $clog2(DIV);
  localparam int CONV_W = $clog2(CONV_SYS_CLKS + 1);
  localparam int CS_LAT = asc_pkg::CS_SYS_EDGES * DIV + 4;   // select latency bound

  // edge counts at counter width
  localparam logic [CW-1:0]     ADDR_E = CW'(asc_pkg::ADDR_EDGES);
  localparam logic [CW-1:0]     SAMP_E = CW'(asc_pkg::SAMPLE_EDGE);
  localparam logic [CW-1:0]     LSB_E  = CW'(asc_pkg::LSB_EDGE);
  localparam logic [CW-1:0]     LAST_E = CW'(asc_pkg::LAST_EDGE);
  localparam logic [1:0]        CS_E   = 2'(asc_pkg::CS_SYS_EDGES);
  localparam logic [DIV_W-1:0]  DIV_E  = DIV_W'(DIV - 1);
  localparam logic [CONV_W-1:0] CONV_E = CONV_W'(CONV_SYS_CLKS);

  // refuse settings the logic cannot serve
  if (DIV < 2) begin : g_chk_div
    $error("system clock must be at least two reference clocks");
  end
  if (CS_LAT > 1000 || CONV_SYS_CLKS < 1) begin : g_chk_len
    $error("system clock too slow or conversion length zero");
  end

  // whole state of the port
  typedef struct packed {
    logic [DIV_W-1:0]              div;       // system clock divider
    logic                          cs_seen;   // last select level seen
    logic [1:0]                    cs_wait;   // ticks left to qualify select
    logic                          cs_act;    // select qualified, link enabled
    logic                          clk_prev;  // shift clock one cycle ago
    logic [CW-1:0]                 fall_cnt;  // shift clock falls this transfer
    logic [CW-1:0]                 rise_cnt;  // shift clock rises this transfer
    logic [asc_pkg::ADDR_BITS-1:0] addr;      // address shift register
    logic [asc_pkg::ADDR_BITS-1:0] chan;      // latched channel address
    logic [RB-1:0]                 shreg;     // result shift register
    logic [RB-1:0]                 result;    // last finished conversion
    logic [RB-1:0]                 sample;    // held input sample
    logic                          sampling;  // sampling window open
    asc_pkg::asc_conv_t            conv;      // conversion controller state
    logic [CONV_W-1:0]             conv_cnt;  // ticks left in conversion
    logic                          data_out;  // serial output level
    logic                          oe;        // serial output enable
    logic                          eoc;       // end of conversion flag
  } asc_state_t;

  localparam asc_state_t RST_STATE = '{
    div: '0, cs_seen: 1'b1, cs_wait: '0, cs_act: 1'b0, clk_prev: 1'b0,
    fall_cnt: '0, rise_cnt: '0, addr: '0, chan: '0, shreg: '0, result: '0,
    sample: '0, sampling: 1'b0, conv: asc_pkg::ASC_IDLE, conv_cnt: '0,
    data_out: 1'b0, oe: 1'b0, eoc: 1'b1};

  asc_state_t s_q;                                  // registered state
  asc_state_t s_d;                                  // next state
  logic [asc_pkg::LINK_PINS-1:0] pins_s;            // synchronised pins
  logic                          cs_s;              // select level, active low
  logic                          clk_s;             // shift clock level
  logic                          addr_s;            // address level
  logic                          tick;              // internal clock falling edge
  logic                          rise;              // shift clock rising edge
  logic                          fall;              // shift clock falling edge
  logic [CW-1:0]                 fall_next;         // fall count after this edge
  logic [CW-1:0]                 rise_next;         // rise count after this edge
  logic [RB-1:0]                 shift_next;        // result register after a shift
  logic [asc_pkg::ADDR_BITS-1:0] addr_next;         // address after a capture
  logic [RB-1:0]                 mux_val;           // selected channel value
  logic                          res_msb;           // msb of stored result
  logic                          shift_msb;         // bit shown after next fall

  // route a channel to the converter; unused codes give zero
  function automatic logic [RB-1:0] chan_value(
    input logic [asc_pkg::ADDR_BITS-1:0]               ch,
    input logic [asc_pkg::CHAN_COUNT*RB-1:0]           bus
  );
    logic [RB-1:0] v;
    v = '0;
    for (int k = 0; k < asc_pkg::CHAN_COUNT; k++) begin
      if (ch == asc_pkg::ADDR_BITS'(k)) begin
        v = bus[k*RB +: RB];
      end
    end
    return v;
  endfunction : chan_value

  // bring select, shift clock and address into the clock domain
  asc_sync #(
    .WIDTH   (asc_pkg::LINK_PINS),
    .RST_VAL (3'h4)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_d       ({i_cs_n, i_io_clk, i_address}),
    .o_q       (pins_s)
  );

  assign cs_s       = pins_s[2];
  assign clk_s      = pins_s[1];
  assign addr_s     = pins_s[0];
  assign tick       = (s_q.div == DIV_E);
  assign rise       = clk_s & ~s_q.clk_prev;
  assign fall       = ~clk_s & s_q.clk_prev;
  assign fall_next  = s_q.fall_cnt + 1'b1;
  assign rise_next  = s_q.rise_cnt + 1'b1;
  assign shift_next = {s_q.shreg[RB-2:0], 1'b0};
  assign addr_next  = {s_q.addr[asc_pkg::ADDR_BITS-2:0], addr_s};
  assign mux_val    = chan_value(s_q.chan, i_analog_inputs);
  assign res_msb    = s_q.result[RB-1];
  assign shift_msb  = s_q.shreg[RB-2];

  // next state of the whole port
  always_comb begin
    s_d          = s_q;
    s_d.div      = tick ? '0 : s_q.div + 1'b1;
    s_d.clk_prev = clk_s;

    // conversion controller, runs on internal clock ticks
    if (s_q.conv == asc_pkg::ASC_CONVERT && tick) begin
      s_d.conv_cnt = s_q.conv_cnt - 1'b1;
      if (s_d.conv_cnt == '0) begin
        s_d.result = s_q.sample;           // new result ready for readout
        s_d.eoc    = 1'b1;
        s_d.conv   = asc_pkg::ASC_IDLE;
      end
    end

    // select qualification: any change restarts the wait
    if (cs_s != s_q.cs_seen) begin
      s_d.cs_seen = cs_s;
      s_d.cs_wait = CS_E;
    end else if (tick && s_q.cs_wait != '0) begin
      s_d.cs_wait = s_q.cs_wait - 1'b1;
      if (s_d.cs_wait == '0) begin
        s_d.cs_act = ~s_q.cs_seen;
        s_d.oe     = ~s_q.cs_seen;
        if (!s_q.cs_seen) begin
          // fresh transfer: clear counters, show previous msb
          s_d.fall_cnt = '0;
          s_d.rise_cnt = '0;
          s_d.sampling = 1'b0;
          s_d.shreg    = s_q.result;
          s_d.data_out = s_q.result[RB-1];
        end
      end
    end else if (s_q.cs_act && s_q.cs_wait == '0) begin
      // link frozen while a select change waits
      // address capture on the first rising edges only
      if (rise && s_q.rise_cnt != ADDR_E) begin
        s_d.rise_cnt = rise_next;
        s_d.addr     = addr_next;
        if (rise_next == ADDR_E) begin
          s_d.chan = addr_next;
        end
      end
      // result shifting and conversion start on falling edges
      if (fall && s_q.fall_cnt != LAST_E) begin
        s_d.fall_cnt = fall_next;
        s_d.shreg    = shift_next;
        s_d.data_out = (fall_next == LAST_E) ? 1'b0 : shift_next[RB-1];
        if (fall_next == SAMP_E) begin
          s_d.sampling = 1'b1;
        end
        if (fall_next == LAST_E) begin
          s_d.sampling = 1'b0;
          s_d.eoc      = 1'b0;
          s_d.conv     = asc_pkg::ASC_CONVERT;
          s_d.conv_cnt = CONV_E;
        end
      end
    end

    // track the selected channel while the window is open
    if (s_q.sampling) begin
      s_d.sample = mux_val;
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_data_out    = s_q.data_out;
  assign o_data_out_oe = s_q.oe;
  assign o_eoc         = s_q.eoc;
  assign o_sampling    = s_q.sampling;
  assign o_chan_sel    = s_q.chan;

  // checks on the port behaviour
  AST_MUX_ROUTE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.sampling |=> s_q.sample == $past(mux_val))
    else $error("sample does not follow selected channel");
  AST_CS_ENABLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(cs_s) |-> ##[1:CS_LAT] (o_data_out_oe || cs_s))
    else $error("select fall did not enable the port in time");
  AST_CS_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_data_out_oe) |-> s_q.fall_cnt == '0 && s_q.rise_cnt == '0)
    else $error("counters not cleared on enable");
  AST_CS_DISABLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !s_q.cs_act ##1 !s_q.cs_act |-> $stable(s_q.addr) && $stable(s_q.fall_cnt))
    else $error("link inputs acted on while disabled");
  AST_HIZ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(cs_s) |-> ##[1:CS_LAT] (!o_data_out_oe || !cs_s))
    else $error("result output still driven after deselect");
  AST_MSB_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_data_out_oe) |-> o_data_out == $past(res_msb))
    else $error("first bit is not the previous result msb");
  AST_SHIFT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.cs_act && s_q.cs_wait == '0 && fall && s_q.fall_cnt < LSB_E
      |=> o_data_out == $past(shift_msb))
    else $error("falling edge did not advance the result bit");
  AST_ZERO_TAIL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.cs_act && s_q.fall_cnt == LAST_E |-> !o_data_out)
    else $error("output not low after the tenth edge");
  AST_EOC_FALL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.cs_act && s_q.cs_wait == '0 && fall && s_q.fall_cnt == LSB_E |=> !o_eoc)
    else $error("end flag not lowered at the tenth edge");
  AST_EOC_BUSY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_eoc != (s_q.conv == asc_pkg::ASC_CONVERT))
    else $error("end flag disagrees with conversion state");
  AST_ADDR_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.rise_cnt == ADDR_E && s_d.rise_cnt == ADDR_E |=> $stable(s_q.chan))
    else $error("address changed after its four bits");
  AST_SAMPLE_WIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_q.sampling |-> s_q.fall_cnt >= SAMP_E && s_q.fall_cnt < LAST_E)
    else $error("sampling outside its window");
  AST_CONV_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_eoc) |-> s_q.conv == asc_pkg::ASC_CONVERT && s_q.conv_cnt == CONV_E)
    else $error("conversion not handed to the controller");
endmodule : asc_port

// [testbench/asc_host_model.sv]
// host serial master model driving select, shift clock and address
`timescale 1ns/1ns
module asc_host_model (
  input  wire logic i_ref_clk, // reference clock
  input  wire logic i_data,    // resolved result wire
  input  wire logic i_eoc,     // end of conversion flag
  output logic      o_cs_n,    // chip select, active low
  output logic      o_io_clk,  // shift clock, still outside frames
  output logic      o_address  // serial address
);
  // pins idle: deselected, clock low
  initial begin
    o_cs_n = 1'b1;
    o_io_clk = 1'b0;
    o_address = 1'b0;
  end
  // wait n edges, then move just after the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : wait_clk
  // change select and let the qualification finish
  task automatic sel(input logic v);
    wait_clk(1);
    o_cs_n = v;
    wait_clk(16);
  endtask : sel
  // one frame of n clocks; result bits collected msb first
  task automatic xfer(input logic [3:0] ch, input int n, output logic [15:0] bits);
    int w;
    w = 0;
    while (i_eoc !== 1'b1 && w < 500) begin
      wait_clk(1);
      w++;
    end
    sel(1'b0);
    bits = {15'h0000, i_data};
    for (int k = 1; k <= n; k++) begin
      // address after the fourth bit is ignored, so it just toggles
      o_address = (k <= 4) ? ch[4-k] : ~o_address;
      wait_clk(4);
      o_io_clk = 1'b1;
      wait_clk(8);
      o_io_clk = 1'b0;
      wait_clk(4);
      bits = {bits[14:0], i_data};
    end
    o_address = ~o_address;
    sel(1'b1);
  endtask : xfer
endmodule : asc_host_model

// [testbench/asc_port_tb.sv]
// self-checking bench for the serial converter control port
`timescale 1ns/1ns
module asc_port_tb;
  logic        i_ref_clk, i_rst;           // clock and reset
  logic [109:0] analog;                    // channel values
  logic        cs_n, io_clk, address;      // host pins
  logic        data_out, data_oe, eoc;     // port outputs
  logic        sampling, last_q, samp_seen, eoc_fell;
  logic        clr;                        // clears the frame flags
  wire         data_wire;                  // resolved result pin
  logic [3:0]  chan_sel;                   // multiplexer selection
  logic [9:0]  prev;                       // result expected next
  int          fails, checks;

  // undriven pin shows the inverse of its last driven level
  assign data_wire = data_oe ? data_out : ~last_q;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      last_q <= 1'b0;
    end else if (data_oe) begin
      last_q <= data_out;
    end
    if (clr) begin
      samp_seen <= 1'b0;
      eoc_fell  <= 1'b0;
    end else begin
      if (sampling) samp_seen <= 1'b1;
      if (eoc === 1'b0) eoc_fell <= 1'b1;
    end
  end

  asc_port #(.SYS_CLK_NS(16), .CONV_SYS_CLKS(2)) dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_io_clk(io_clk),
    .i_address(address), .i_analog_inputs(analog), .o_data_out(data_out),
    .o_data_out_oe(data_oe), .o_eoc(eoc), .o_sampling(sampling), .o_chan_sel(chan_sel));

  asc_host_model host (.i_ref_clk(i_ref_clk), .i_data(data_wire), .i_eoc(eoc),
    .o_cs_n(cs_n), .o_io_clk(io_clk), .o_address(address));

  // distinct value for each channel
  function automatic logic [9:0] chv(input int k);
    return 10'((k * 93) + 17);
  endfunction : chv

  // compare one result and count it
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one frame, judged against the previous result
  task automatic run(input logic [3:0] ch, input int n);
    logic [15:0] bits;
    clr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    clr = 1'b0;
    host.xfer(ch, n, bits);
    chk("result bits", {prev, 6'h00} >> (15 - n), bits);
    chk("eoc fell", 16'(n >= 10), 16'(eoc_fell));
    chk("eoc back", 16'h0001, 16'(eoc));
    chk("sampling", 16'(n >= 4), 16'(samp_seen));
    chk("chan sel", 16'(ch), 16'(chan_sel));
    if (n >= 10) prev = (ch < 4'hb) ? chv(int'(ch)) : 10'h000;
  endtask : run

  // outputs after reset
  task automatic t_reset();
    chk("oe", 16'h0000, 16'(data_oe));
    chk("eoc", 16'h0001, 16'(eoc));
    chk("sel", 16'h0000, 16'(chan_sel));
    $display("test reset done");
  endtask : t_reset

  // every channel code in turn
  task automatic t_channels();
    for (int c = 0; c < 16; c++) run(4'(c), 10);
    $display("test channels done");
  endtask : t_channels

  // frames longer than ten clocks return zeros
  task automatic t_long();
    run(4'h4, 15);
    run(4'h7, 15);
    $display("test long done");
  endtask : t_long

  // nine clocks start no conversion, old result stays
  task automatic t_short();
    run(4'ha, 9);
    run(4'h6, 10);
    $display("test short done");
  endtask : t_short

  // select alone enables and disables the output
  task automatic t_select();
    host.sel(1'b0);
    chk("oe on", 16'h0001, 16'(data_oe));
    chk("msb", 16'(prev[9]), 16'(data_wire));
    host.sel(1'b1);
    chk("oe off", 16'h0000, 16'(data_oe));
    $display("test select done");
  endtask : t_select

  // counts and verdict
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // reference clock, 4 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // watchdog
  initial begin
    #300000;
    fails++;
    final_report();
  end

  // main sequence
  initial begin
    i_rst = 1'b1;
    fails = 0;
    checks = 0;
    prev = 10'h000;
    clr = 1'b0;
    for (int k = 0; k < 11; k++) analog[k*10 +: 10] = chv(k);
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_channels();
    t_long();
    t_short();
    t_select();
    final_report();
  end
endmodule : asc_port_tb
